// ### isgo_core.v
// initialization sequencer with done status and global overrides
`timescale 1ns/10ps
`include "isgo_regs.vh"
`default_nettype none
module isgo_core (
    // clock, reset, enable
    input wire clock_i,
    input wire rst_n_i,
    input wire ce_i,
    // register port
    input wire [`ISGO_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // configuration pins
    input wire configuration_request_n_i,
    input wire user_startup_clock_i,
    input wire global_output_enable_i,
    input wire global_register_clear_n_i,
    // done pin, open drain
    input wire init_done_i,
    output reg init_done_o,
    output reg init_done_oe_n_o,
    // user I/O pins
    input wire [`ISGO_USER_W-1:0] user_io_i,
    output reg [`ISGO_USER_W-1:0] user_io_o,
    output reg [`ISGO_USER_W-1:0] user_io_oe_n_o,
    output reg [`ISGO_OPT_W-1:0] pin_pullup_o,
    output reg user_mode_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_CONFIG = 2'b01;
    localparam ST_INIT = 2'b10;
    localparam ST_USER = 2'b11;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`ISGO_OPT_W-1:0] opt_q;
    reg [`ISGO_INIT_LEN_W-1:0] init_len_q;
    reg [`ISGO_INIT_LEN_W-1:0] cnt_q;
    reg [`ISGO_USER_W-1:0] user_data_q;
    reg [`ISGO_USER_W-1:0] user_reg_q;
    reg frame_loaded_q;
    reg cfg_done_q;
    reg inputs_q;
    wire opt_user_startup_clock;
    wire opt_done;
    wire opt_oe;
    wire opt_clr;
    wire tick_usr;
    wire tick;
    wire cfg_req;
    wire frame_wr;
    wire data_end_wr;
    wire dev_clear;
    wire io_enable;
    wire user_mode_d;

    assign opt_user_startup_clock = opt_q[`ISGO_OPT_USER_STARTUP_CLOCK_BIT];
    assign opt_done = opt_q[`ISGO_OPT_DONE_BIT];
    assign opt_oe = opt_q[`ISGO_OPT_OE_BIT];
    assign opt_clr = opt_q[`ISGO_OPT_CLR_BIT];
    assign cfg_req = ~configuration_request_n_i;
    assign frame_wr = wr_i && (addr_i == `ISGO_OFF_CTRL) && wdata_i[`ISGO_CTRL_FRAME_BIT];
    assign data_end_wr = wr_i && (addr_i == `ISGO_OFF_CTRL) && wdata_i[`ISGO_CTRL_DATA_BIT];
    // disabled override pins are ignored, acting as plain I/O
    assign dev_clear = opt_clr & ~global_register_clear_n_i;
    assign io_enable = ~(opt_oe & ~global_output_enable_i);
    // user mode starts only once the done pin is released
    assign user_mode_d = (state_d == ST_USER) && (state_q == ST_USER || !opt_done ||
        init_done_oe_n_o);

    // ----------------------------------------------------------------
    // start-up clock pacing
    // ----------------------------------------------------------------
    isgo_edge u_usr_edge (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .level_i(user_startup_clock_i),
        .rise_o(tick_usr)
    );
    assign tick = opt_user_startup_clock ? tick_usr : ce_i;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (!cfg_req) begin
                    state_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (cfg_done_q) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                if (tick && cnt_q == init_len_q) begin
                    state_d = ST_USER;
                end
            end
            default: begin
                state_d = ST_USER;
            end
        endcase
        if (cfg_req) begin
            state_d = ST_IDLE;
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            opt_q <= `ISGO_OPT_RST;
            init_len_q <= `ISGO_INIT_LEN_RST;
            cnt_q <= {`ISGO_INIT_LEN_W{1'b0}};
            frame_loaded_q <= 1'b0;
            cfg_done_q <= 1'b0;
            user_data_q <= `ISGO_USER_RST;
            user_reg_q <= `ISGO_USER_RST;
            inputs_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            inputs_q <= init_done_i;
            if (state_q == ST_INIT) begin
                if (tick) begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end else begin
                cnt_q <= {`ISGO_INIT_LEN_W{1'b0}};
            end
            if (state_q == ST_IDLE) begin
                frame_loaded_q <= 1'b0;
                cfg_done_q <= 1'b0;
            end else if (state_q == ST_CONFIG) begin
                if (frame_wr) begin
                    frame_loaded_q <= 1'b1;
                end
                if (data_end_wr && (frame_loaded_q || frame_wr)) begin
                    cfg_done_q <= 1'b1;
                end
            end
            // options are written only in configuration, before the first frame is loaded
            if (wr_i && addr_i == `ISGO_OFF_OPTIONS && state_q == ST_CONFIG && !frame_loaded_q) begin
                opt_q <= wdata_i[`ISGO_OPT_W-1:0];
            end
            if (wr_i && addr_i == `ISGO_OFF_INIT_LEN) begin
                init_len_q <= wdata_i[`ISGO_INIT_LEN_W-1:0];
            end
            if (dev_clear) begin
                user_data_q <= `ISGO_USER_RST;
            end else if (wr_i && addr_i == `ISGO_OFF_USER_DATA) begin
                user_data_q <= wdata_i[`ISGO_USER_W-1:0];
            end
            if (dev_clear) begin
                user_reg_q <= `ISGO_USER_RST;
            end else if (state_q == ST_USER) begin
                user_reg_q <= user_data_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            init_done_o <= 1'b0;
            init_done_oe_n_o <= 1'b1;
            user_io_o <= `ISGO_USER_RST;
            user_io_oe_n_o <= {`ISGO_USER_W{1'b1}};
            pin_pullup_o <= {`ISGO_OPT_W{1'b1}};
            user_mode_o <= 1'b0;
        end else if (ce_i) begin
            init_done_o <= 1'b0;
            // float until a frame is loaded with the done option set, pull low until init ends
            if (cfg_req || state_d == ST_IDLE || state_d == ST_USER) begin
                init_done_oe_n_o <= 1'b1;
            end else begin
                init_done_oe_n_o <= ~(opt_done && (frame_loaded_q || frame_wr));
            end
            user_mode_o <= user_mode_d;
            // disabled option pins: weak pull-up during configuration
            if (!user_mode_d) begin
                pin_pullup_o <= ~opt_q;
                user_io_oe_n_o <= {`ISGO_USER_W{1'b1}};
            end else begin
                pin_pullup_o <= {`ISGO_OPT_W{1'b0}};
                user_io_oe_n_o <= {`ISGO_USER_W{~io_enable}};
            end
            user_io_o <= dev_clear ? `ISGO_USER_RST : user_reg_q;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            if (!rd_i) begin
                rdata_o <= 32'h00000000;
            end else if (addr_i == `ISGO_OFF_OPTIONS) begin
                rdata_o <= {28'h0000000, opt_q};
            end else if (addr_i == `ISGO_OFF_STATUS) begin
                rdata_o <= {22'h000000, user_io_i, inputs_q, global_register_clear_n_i,
                    global_output_enable_i, frame_loaded_q, state_q};
            end else if (addr_i == `ISGO_OFF_INIT_LEN) begin
                rdata_o <= {16'h0000, init_len_q};
            end else if (addr_i == `ISGO_OFF_USER_DATA) begin
                rdata_o <= {28'h0000000, user_data_q};
            end else begin
                rdata_o <= 32'h00000000;
            end
        end
    end
endmodule
`default_nettype wire

// ### isgo_regs.vh
// constants of the initialization status and global override block
`ifndef ISGO_REGS_VH
`define ISGO_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ISGO_ADDR_W 4
`define ISGO_OFF_OPTIONS 4'h0
`define ISGO_OFF_CTRL 4'h1
`define ISGO_OFF_STATUS 4'h2
`define ISGO_OFF_INIT_LEN 4'h3
`define ISGO_OFF_USER_DATA 4'h4

// ----------------------------------------------------------------
// option bits
// ----------------------------------------------------------------
`define ISGO_OPT_USER_STARTUP_CLOCK_BIT 0
`define ISGO_OPT_DONE_BIT 1
`define ISGO_OPT_OE_BIT 2
`define ISGO_OPT_CLR_BIT 3
`define ISGO_OPT_W 4
`define ISGO_OPT_RST 4'h0

// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define ISGO_CTRL_FRAME_BIT 0
`define ISGO_CTRL_DATA_BIT 1

// ----------------------------------------------------------------
// timing and user I/O
// ----------------------------------------------------------------
`define ISGO_INIT_LEN_W 16
`define ISGO_INIT_LEN_RST 16'h0010
`define ISGO_USER_W 4
`define ISGO_USER_RST 4'h0

`endif

// ### isgo_edge.v
// rising edge detector for one input level
`timescale 1ns/10ps
`default_nettype none
module isgo_edge (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    input wire ce_i,
    // level in, edge out
    input wire level_i,
    output wire rise_o
);
    reg last_q;
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            last_q <= 1'b0;
        end else if (ce_i) begin
            last_q <= level_i;
        end
    end
    assign rise_o = ce_i & level_i & ~last_q;
endmodule
`default_nettype wire

// ### isgo_core_sva.sv
// assertion checker for the init status and override block
`timescale 1ns/10ps
`include "isgo_regs.vh"
`default_nettype none
module isgo_core_sva (
    // clock and register port
    input wire clock_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [`ISGO_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    // pins
    input wire configuration_request_n_i,
    input wire user_startup_clock_i,
    input wire global_output_enable_i,
    input wire global_register_clear_n_i,
    input wire init_done_o,
    input wire init_done_oe_n_o,
    input wire [`ISGO_USER_W-1:0] user_io_o,
    input wire [`ISGO_USER_W-1:0] user_io_oe_n_o,
    input wire [`ISGO_OPT_W-1:0] pin_pullup_o,
    input wire user_mode_o
);
    reg [3:0] opt_q;
    reg [3:0] age_q;
    reg clk_q;
    wire frame_wr = ce_i && wr_i && addr_i == `ISGO_OFF_CTRL && wdata_i[0];
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // options seen through the pull-ups, age of the last start-up clock rise
    always @(posedge clock_i) begin
        clk_q <= user_startup_clock_i;
        opt_q <= user_mode_o ? opt_q : ~pin_pullup_o;
        if (user_startup_clock_i && !clk_q) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    a_done_float: assert property (!configuration_request_n_i && ce_i |=> init_done_oe_n_o)
        else $error("done pin driven during request");
    a_done_open: assert property (init_done_o == 1'b0)
        else $error("done pin data not low");
    a_done_cause: assert property ($fell(init_done_oe_n_o) |->
        $past(frame_wr) || $past(frame_wr, 2)) else $error("done low without frame");
    a_mode_released: assert property (user_mode_o |-> init_done_oe_n_o)
        else $error("user mode with done held low");
    a_io_override: assert property (user_mode_o && opt_q[2] && !global_output_enable_i && ce_i
        |=> &user_io_oe_n_o) else $error("io not tri-stated");
    a_clear_io: assert property (user_mode_o && opt_q[3] && !global_register_clear_n_i && ce_i
        |=> user_io_o == 4'h0) else $error("io data not cleared");
    a_io_config: assert property (!user_mode_o && !$past(user_mode_o) |-> &user_io_oe_n_o)
        else $error("io driven outside user mode");
    a_start_paced: assert property ($rose(user_mode_o) && opt_q[0] |-> age_q < 4'h8)
        else $error("init end not on start-up clock");
endmodule
bind isgo_core isgo_core_sva isgo_core_sva_inst (.clock_i, .rst_n_i, .ce_i, .addr_i, .wdata_i,
    .wr_i, .configuration_request_n_i, .user_startup_clock_i, .global_output_enable_i,
    .global_register_clear_n_i, .init_done_o, .init_done_oe_n_o, .user_io_o,
    .user_io_oe_n_o, .pin_pullup_o, .user_mode_o);
`default_nettype wire

// ### isgo_monitor.sv
// monitor on the done wire: pull-up, synchronizer, rise counter
`timescale 1ns/10ps
`default_nettype none
module isgo_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // done pin
    input wire logic done_oe_n_i,
    input wire logic done_i,
    output wire logic done_wire_o,
    output logic [7:0] rise_count_o
);
    logic [2:0] sync_q;
    // the pull-up wins while the pin is released
    assign done_wire_o = done_oe_n_i ? 1'h1 : done_i;
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_q <= 3'h7;
            rise_count_o <= 8'h00;
        end else begin
            sync_q <= {sync_q[1:0], done_wire_o};
            if (sync_q[1] && !sync_q[2]) begin
                rise_count_o <= rise_count_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### isgo_core_bench.sv
// self-checking bench for the init status and override block
`timescale 1ns/10ps
`include "isgo_regs.vh"
`default_nettype none
module isgo_core_bench;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic ce_i = 1'h1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic req_n = 1'h0;
    logic sclk = 1'h0;
    logic goe = 1'h1;
    logic clr_n = 1'h1;
    wire [31:0] rdata;
    wire done_o, done_oe_n, done_w, um;
    wire [3:0] uo, uo_oe_n, pu;
    wire [7:0] rises;
    int err_count = 0;
    int num_checks = 0;
    isgo_core isgo_core_inst (.clock_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o(rdata), .configuration_request_n_i(req_n), .user_startup_clock_i(sclk),
        .global_output_enable_i(goe), .global_register_clear_n_i(clr_n), .init_done_i(done_w),
        .init_done_o(done_o), .init_done_oe_n_o(done_oe_n), .user_io_i(uo | uo_oe_n),
        .user_io_o(uo), .user_io_oe_n_o(uo_oe_n), .pin_pullup_o(pu), .user_mode_o(um));
    isgo_monitor isgo_monitor_inst (.clock_i, .rst_n_i, .done_oe_n_i(done_oe_n),
        .done_i(done_o), .done_wire_o(done_w), .rise_count_o(rises));
    initial forever #10 clock_i = ~clock_i;
    initial forever begin
        repeat (8) @(posedge clock_i);
        sclk <= ~sclk;
    end
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'h0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic setp(input logic g, input logic c);
        @(posedge clock_i);
        goe <= g;
        clr_n <= c;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic wait_um(input int lim);
        for (int i = 0; i < lim && um !== 1'h1; i++) begin
            @(posedge clock_i);
            #1;
        end
        chk("user mode", 32'h1, um);
        if (um !== 1'h1) wrap_up();
    endtask
    task automatic boot(input logic [3:0] opt);
        @(posedge clock_i);
        req_n <= 1'h0;
        repeat (2) @(posedge clock_i);
        #1 chk("done during request", 32'h1, done_oe_n);
        @(posedge clock_i);
        req_n <= 1'h1;
        wr(`ISGO_OFF_OPTIONS, {28'h0, opt});
        wr(`ISGO_OFF_CTRL, 32'h1);
        #1 chk("pullups", {28'h0, ~opt}, pu);
        repeat (2) @(posedge clock_i);
        #1 chk("done after frame", {31'h0, !opt[1]}, done_oe_n);
        wr(`ISGO_OFF_CTRL, 32'h2);
    endtask
    task automatic done_override();
        boot(4'he);
        repeat (12) @(posedge clock_i);
        #1 chk("early user mode", 32'h0, um);
        wait_um(20);
        chk("done released", 32'h1, done_oe_n);
        repeat (4) @(posedge clock_i);
        #1 chk("done rises", 32'h1, rises);
        wr(`ISGO_OFF_USER_DATA, 32'ha);
        setp(1'h0, 1'h1);
        chk("io oe_n", 32'hf, uo_oe_n);
        chk("io data", 32'ha, uo);
        setp(1'h1, 1'h0);
        chk("io cleared", 32'h0, uo);
        chk("io oe_n", 32'h0, uo_oe_n);
        setp(1'h1, 1'h1);
        rd(`ISGO_OFF_USER_DATA, 32'h0);
    endtask
    task automatic paced();
        boot(4'h1);
        repeat (100) @(posedge clock_i);
        #1 chk("unpaced user mode", 32'h0, um);
        chk("done unused", 32'h1, done_oe_n);
        wait_um(400);
        wr(`ISGO_OFF_USER_DATA, 32'h5);
        setp(1'h0, 1'h0);
        chk("io oe_n", 32'h0, uo_oe_n);
        chk("io kept", 32'h5, uo);
        chk("done rises", 32'h1, rises);
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'h1;
        rd(`ISGO_OFF_INIT_LEN, 32'h10);
        rd(4'hf, 32'h0);
        chk("pullups", 32'hf, pu);
        chk("io oe_n", 32'hf, uo_oe_n);
        done_override();
        paced();
        wrap_up();
    end
endmodule
`default_nettype wire
